// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic                    clk = 1'b0; // 50 ns period
  logic                    rst = 1'b1; // sync reset
  xtal_trim_pkg::bus_req_t req = '0;   // register request
  logic [7:0] rdata, v;
  logic       up, down, bclk, busy;
  logic [4:0] trim, t, res;
  logic [4:0] target = 5'h10; // trim the far side matches
  logic [1:0] reps = 2'h1;    // pulses per bit
  int         err_count = 0;
  int         checks = 0;
  int         cycles = 0;

  initial forever #25 clk = ~clk;

  xtal_trim dut (.CLK_SYS(clk), .RESET(rst), .REG_WR(req.wr), .REG_RD(req.rd),
    .REG_ADDR(req.addr), .REG_WDATA(req.wdata), .REG_RDATA(rdata), .DEMOD_UP(up),
    .DEMOD_DOWN(down), .BIT_CLK(bclk), .XTAL_TRIM(trim), .COUNT_BUSY(busy));
  xtal_far_model far (.clk(clk), .trim(trim), .target(target), .reps(reps),
    .up(up), .down(down), .bclk(bclk));

  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic close_out;
    $display("mismatches %0d of %0d compares", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // one idle edge after each strobe so req is never set twice at once
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask : wr

  // data sampled in the one cycle it stands
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    d = rdata;
  endtask : rd

  // expected count: ups minus downs, wrapping in eight bits
  function automatic logic [7:0] exp_count(input int k, n, b, r);
    int ups;
    ups = b > 0 ? n * r : (b < 0 ? 0 : n * r / 2);
    return 8'((k != 1 ? ups : 0) - (k != 0 ? n * r - ups : 0));
  endfunction : exp_count

  // start a window just after a bit edge, wait it out, read the count
  task automatic run(input logic [3:0] c, output logic [7:0] d);
    int i;
    @(negedge bclk);
    @(posedge clk);
    wr(xtal_trim_pkg::OFS_CTRL, {4'h1, c});
    rd(xtal_trim_pkg::OFS_STATUS, d);
    check(d, 8'h01);
    for (i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk);
    check({7'h00, busy}, 8'h00);
    rd(xtal_trim_pkg::OFS_COUNT, d);
  endtask : run

  // successive approximation as a host would run it
  task automatic cal(output logic [4:0] r);
    logic [4:0] pres;
    logic [5:0] step; // one bit wider so 32 fits
    logic       pos;
    logic [7:0] d;
    pres = 5'h00;
    step = 6'h20;
    pos = 1'b0;
    do begin
      step = step >> 1;
      if (pos) pres = pres - step[4:0];
      else pres = pres + step[4:0];
      wr(xtal_trim_pkg::OFS_TRIM, {3'h0, pres});
      run(4'h8, d);
      pos = $signed(d) > 0;
    end while (step > 6'h01);
    if (pos) pres = pres - 5'h01;
    wr(xtal_trim_pkg::OFS_TRIM, {3'h0, pres});
    r = pres;
  endtask : cal

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    void'($urandom(32'hf3d9_bc20));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values, read data lasting one cycle, unmapped place
    rd(xtal_trim_pkg::OFS_TRIM, v);
    check(v, 8'h10);
    @(posedge clk);
    check(rdata, 8'h00);
    check({3'h0, trim}, 8'h10);
    rd(4'(4 + $urandom_range(11, 0)), v);
    check(v, 8'h00);
    // every window length and pulse kind on target
    for (int k = 0; k < 4; k++) begin
      for (int w = 0; w < 4; w++) begin
        run({2'(k), 2'(w)}, v);
        check(v, exp_count(k, 8 << w, 0, 1));
      end
    end
    // random trims: sign of count follows the load
    repeat (3) begin
      t = 5'($urandom_range(31, 0));
      wr(xtal_trim_pkg::OFS_TRIM, {3'h0, t});
      rd(xtal_trim_pkg::OFS_TRIM, v);
      check(v, {3'h0, t});
      check({3'h0, trim}, {3'h0, t});
      run(4'h9, v);
      check(v, exp_count(2, 16, int'(t > 5'h10) - int'(t < 5'h10), 1));
    end
    // triple pulses over 64 bits push past both limits
    reps <= 2'h3;
    wr(xtal_trim_pkg::OFS_TRIM, 8'h00);
    run(4'h7, v);
    check(v, exp_count(1, 64, -1, 3));
    wr(xtal_trim_pkg::OFS_TRIM, 8'h1f);
    run(4'h3, v);
    check(v, exp_count(0, 64, 1, 3));
    reps <= 2'h1;
    // full search against both ends and a random target
    for (int j = 0; j < 3; j++) begin
      target <= j == 0 ? 5'h00 : (j == 1 ? 5'h1f : 5'($urandom_range(31, 0)));
      @(posedge clk);
      cal(res);
      check({3'h0, res}, {3'h0, target});
      @(posedge clk);
      check({3'h0, trim}, {3'h0, target});
    end
    close_out();
  end
endmodule : tb_top

// ### xtal_far_model.sv
`timescale 1ns/1ps
// remote 1010 sender seen through the demodulator
module xtal_far_model (
  // clock
  input  wire logic       clk,
  // present trim, matching trim, pulses per bit
  input  wire logic [4:0] trim,
  input  wire logic [4:0] target,
  input  wire logic [1:0] reps,
  // pulse and bit clock pins
  output logic            up,
  output logic            down,
  output logic            bclk
);
  logic bit_v = 1'b0; // current data bit
  // free-running bits: pulses first, then the bit edge, so a window
  // never closes on a pulse that is still in the synchroniser
  initial begin
    {up, down, bclk} = 3'b000;
    forever begin
      bit_v = ~bit_v;
      repeat (reps) begin
        @(posedge clk);
        up   <= (trim > target) || (trim == target && bit_v);
        down <= (trim < target) || (trim == target && !bit_v);
        repeat (4) @(posedge clk);
        {up, down} <= 2'b00;
        repeat (3) @(posedge clk);
      end
      bclk <= 1'b1;
      repeat (4) @(posedge clk);
      bclk <= 1'b0;
      repeat (3) @(posedge clk);
    end
  end
endmodule : xtal_far_model

// ### xtal_trim.sv
`timescale 1ns/1ps
// Functional notes
// - count up, down or both over n bits
// - signed 8-bit count wraps at limits
// - higher trim adds load, lowers frequency
// - trim 16 sits mid tuning range
module xtal_trim (
  // clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       RESET,
  // register port
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [3:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  // demodulator pulses and bit clock, asynchronous
  input  wire logic       DEMOD_UP,
  input  wire logic       DEMOD_DOWN,
  input  wire logic       BIT_CLK,
  // crystal load trim to the analog oscillator
  output logic      [4:0] XTAL_TRIM,
  output logic            COUNT_BUSY
);

  xtal_trim_pkg::bus_req_t req;            // bundled bus request
  logic [3:0]              ctrl;           // window and pulse kind
  logic [4:0]              trim;           // crystal load setting
  logic signed [7:0]       freq_error_count; // signed tally
  logic [6:0]              bits_left;      // bits remaining in window
  logic [6:0]              next_bits;      // window length decoded
  xtal_trim_pkg::est_state_t state;        // estimator state
  logic [2:0]              up_meta;        // up pulse sync and edge
  logic [2:0]              dn_meta;        // down pulse sync and edge
  logic [2:0]              bclk_meta;      // bit clock sync and edge
  logic                    up_evt;         // one up pulse seen
  logic                    dn_evt;         // one down pulse seen
  logic                    bit_evt;        // one bit period elapsed
  logic                    count_up;       // up pulses enabled
  logic                    count_dn;       // down pulses enabled
  logic                    start;          // software start request

  assign req.wr    = REG_WR;
  assign req.rd    = REG_RD;
  assign req.addr  = REG_ADDR;
  assign req.wdata = REG_WDATA;
  assign start     = req.wr && req.addr == xtal_trim_pkg::OFS_CTRL
                     && req.wdata[xtal_trim_pkg::CTRL_START_BIT];

  // pin inputs pass two flops; third stage only for edge detect
  // limitation: a pin pulse shorter than one clock period may be lost,
  // so the demodulator pulses must span at least two clocks
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      up_meta   <= 3'h0;
      dn_meta   <= 3'h0;
      bclk_meta <= 3'h0;
    end else begin
      up_meta   <= {up_meta[1:0], DEMOD_UP};
      dn_meta   <= {dn_meta[1:0], DEMOD_DOWN};
      bclk_meta <= {bclk_meta[1:0], BIT_CLK};
    end
  end

  // rising edges, only from second and third stages
  assign up_evt  = up_meta[1] & ~up_meta[2];
  assign dn_evt  = dn_meta[1] & ~dn_meta[2];
  assign bit_evt = bclk_meta[1] & ~bclk_meta[2];

  // pulse kind selection: both means up minus down
  assign count_up = ctrl[xtal_trim_pkg::CTRL_KIND_LSB +: 2]
                    != xtal_trim_pkg::COUNT_DOWN_BIT;
  assign count_dn = ctrl[xtal_trim_pkg::CTRL_KIND_LSB +: 2]
                    != xtal_trim_pkg::COUNT_UP_BIT;

  // window length: 8 shifted by the two-bit code; taken from the write
  // data, because the control register only takes the new code at the
  // same edge that launches the window
  always_comb begin
    next_bits = xtal_trim_pkg::WIN_BITS_8 << req.wdata[xtal_trim_pkg::CTRL_WIN_LSB +: 2];
  end

  // control register: window, pulse kind
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ctrl <= xtal_trim_pkg::CTRL_RESET;
    end else if (req.wr && req.addr == xtal_trim_pkg::OFS_CTRL) begin
      ctrl <= req.wdata[3:0];
    end
  end

  // trim register; larger value adds load, slowing the crystal
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      trim <= xtal_trim_pkg::TRIM_RESET;
    end else if (req.wr && req.addr == xtal_trim_pkg::OFS_TRIM) begin
      trim <= req.wdata[4:0];
    end
  end

  // estimator window sequencing
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      state     <= xtal_trim_pkg::ST_IDLE;
      bits_left <= 7'h00;
    end else if (start) begin
      // restart wins over a running window
      state     <= xtal_trim_pkg::ST_COUNT;
      bits_left <= next_bits;
    end else begin
      unique case (state)
        xtal_trim_pkg::ST_IDLE: begin
          bits_left <= bits_left;
        end
        xtal_trim_pkg::ST_COUNT: begin
          if (bit_evt) begin
            bits_left <= bits_left - 7'h01;
            if (bits_left == 7'h01) begin
              state <= xtal_trim_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state <= xtal_trim_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // signed tally; natural 8-bit arithmetic gives the wrap
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      freq_error_count <= 8'sh00;
    end else if (start) begin
      // a new window always starts from zero
      freq_error_count <= 8'sh00;
    end else if (state == xtal_trim_pkg::ST_COUNT) begin
      // simultaneous up and down cancel out when both kinds are counted
      freq_error_count <= freq_error_count
                          + ((count_up && up_evt) ? 8'sh01 : 8'sh00)
                          - ((count_dn && dn_evt) ? 8'sh01 : 8'sh00);
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        xtal_trim_pkg::OFS_CTRL:   REG_RDATA <= {4'h0, ctrl};
        xtal_trim_pkg::OFS_TRIM:   REG_RDATA <= {3'h0, trim};
        xtal_trim_pkg::OFS_COUNT:  REG_RDATA <= freq_error_count;
        xtal_trim_pkg::OFS_STATUS: REG_RDATA <= {7'h00, state == xtal_trim_pkg::ST_COUNT};
        default:                   REG_RDATA <= 8'h00;
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  // registered outputs to the oscillator and status pin
  // trim reaches the pin one edge after the register, two after the write
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      XTAL_TRIM  <= xtal_trim_pkg::TRIM_RESET;
      COUNT_BUSY <= 1'b0;
    end else begin
      XTAL_TRIM  <= trim;
      COUNT_BUSY <= state == xtal_trim_pkg::ST_COUNT;
    end
  end

  // assertions; pulse, wrap, hold and window-end antecedents leave out a start in the same cycle,
  // because a restart clears the tally and overrides any pulse;
  // all but the reset check are disabled while reset is held

  // one counted up pulse with no counted down pulse beside it
  sequence s_up_alone;
    state == xtal_trim_pkg::ST_COUNT && !start
    && count_up && up_evt && !(count_dn && dn_evt);
  endsequence

  // one counted down pulse with no counted up pulse beside it
  sequence s_down_alone;
    state == xtal_trim_pkg::ST_COUNT && !start
    && count_dn && dn_evt && !(count_up && up_evt);
  endsequence

  // the edge that takes the last bit of a running window
  sequence s_last_bit;
    state == xtal_trim_pkg::ST_COUNT && !start
    && bit_evt && bits_left == 7'h01;
  endsequence

  // software writes a new crystal trim
  sequence s_trim_write;
    REG_WR && REG_ADDR == xtal_trim_pkg::OFS_TRIM;
  endsequence

  // software reads the signed tally
  sequence s_count_read;
    REG_RD && REG_ADDR == xtal_trim_pkg::OFS_COUNT;
  endsequence

  // below the floor the tally comes round to the top
  AST_WRAP_DOWN: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (state == xtal_trim_pkg::ST_COUNT && !start && freq_error_count == 8'sh80
     && count_dn && dn_evt && !(count_up && up_evt))
    |=> freq_error_count == 8'sh7f)
    else $error("count did not wrap to +127");

  // above the top the tally comes round to the floor
  AST_WRAP_UP: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (state == xtal_trim_pkg::ST_COUNT && !start && freq_error_count == 8'sh7f
     && count_up && up_evt && !(count_dn && dn_evt))
    |=> freq_error_count == 8'sh80)
    else $error("count did not wrap to -128");

  // every lone up pulse adds exactly one, wrap included
  AST_UP_STEP: assert property (@(posedge CLK_SYS) disable iff (RESET)
    s_up_alone |=> freq_error_count == $past(freq_error_count) + 8'sh01)
    else $error("up pulse not counted as one");

  // every lone down pulse takes exactly one away, wrap included
  AST_DOWN_STEP: assert property (@(posedge CLK_SYS) disable iff (RESET)
    s_down_alone |=> freq_error_count == $past(freq_error_count) - 8'sh01)
    else $error("down pulse not counted as one");

  // a down pulse is ignored while only up pulses are counted
  AST_UP_ONLY: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (state == xtal_trim_pkg::ST_COUNT && !start
     && ctrl[xtal_trim_pkg::CTRL_KIND_LSB +: 2] == xtal_trim_pkg::COUNT_UP_BIT
     && dn_evt && !up_evt)
    |=> $stable(freq_error_count))
    else $error("down pulse counted in up-only mode");

  // an up pulse is ignored while only down pulses are counted
  AST_DOWN_ONLY: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (state == xtal_trim_pkg::ST_COUNT && !start
     && ctrl[xtal_trim_pkg::CTRL_KIND_LSB +: 2] == xtal_trim_pkg::COUNT_DOWN_BIT
     && up_evt && !dn_evt)
    |=> $stable(freq_error_count))
    else $error("up pulse counted in down-only mode");

  // the window length comes from the code written with the start
  AST_WINDOW_LEN: assert property (@(posedge CLK_SYS) disable iff (RESET)
    start |=> bits_left == (xtal_trim_pkg::WIN_BITS_8
                            << $past(REG_WDATA[xtal_trim_pkg::CTRL_WIN_LSB +: 2])))
    else $error("window length wrong");

  // a start clears the tally and raises busy one edge later
  AST_WINDOW_OPEN: assert property (@(posedge CLK_SYS) disable iff (RESET)
    start |=> (state == xtal_trim_pkg::ST_COUNT && freq_error_count == 8'sh00)
              ##1 COUNT_BUSY)
    else $error("window did not open cleanly");

  // n bit edges close the window, and busy drops one edge later
  AST_WINDOW_END: assert property (@(posedge CLK_SYS) disable iff (RESET)
    s_last_bit |=> state == xtal_trim_pkg::ST_IDLE ##1 !COUNT_BUSY)
    else $error("window did not close after n bits");

  // a running window always has bits left to take
  AST_BITS_LEFT: assert property (@(posedge CLK_SYS) disable iff (RESET)
    state == xtal_trim_pkg::ST_COUNT |-> bits_left != 7'h00)
    else $error("running window with no bits left");

  // outside a window the tally holds for the host to read
  AST_IDLE_HOLD: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (state == xtal_trim_pkg::ST_IDLE && !start) |=> $stable(freq_error_count))
    else $error("count moved outside window");

  // the oscillator sees a written trim two edges after the write
  AST_TRIM_OUT: assert property (@(posedge CLK_SYS) disable iff (RESET)
    s_trim_write |=> ##1 XTAL_TRIM == $past(REG_WDATA[4:0], 2))
    else $error("trim output not updated");

  // the tally read back is the one held at the read strobe
  AST_COUNT_READ: assert property (@(posedge CLK_SYS) disable iff (RESET)
    s_count_read |=> REG_RDATA == $past(freq_error_count))
    else $error("count readback wrong");

  // read data stand only in the cycle after a read strobe
  AST_READ_IDLE: assert property (@(posedge CLK_SYS) disable iff (RESET)
    !REG_RD |=> REG_RDATA == 8'h00)
    else $error("read data outside the read cycle");

  // leaving reset the trim sits mid range, inside and at the pin
  AST_TRIM_RESET: assert property (@(posedge CLK_SYS)
    ($past(RESET) && !RESET)
    |-> trim == xtal_trim_pkg::TRIM_RESET && XTAL_TRIM == xtal_trim_pkg::TRIM_RESET)
    else $error("trim reset not centre");

endmodule : xtal_trim

// ### xtal_trim_pkg.sv
package xtal_trim_pkg;

  // counting window choices, in received bits
  localparam logic [1:0] WIN_8          = 2'h0;
  localparam logic [1:0] WIN_16         = 2'h1;
  localparam logic [1:0] WIN_32         = 2'h2;
  localparam logic [1:0] WIN_64         = 2'h3;

  // pulse kinds to count
  localparam logic [1:0] COUNT_UP_BIT   = 2'h0;
  localparam logic [1:0] COUNT_DOWN_BIT = 2'h1;

  // register offsets on the plain port
  localparam logic [3:0] OFS_CTRL       = 4'h0;
  localparam logic [3:0] OFS_TRIM       = 4'h1;
  localparam logic [3:0] OFS_COUNT      = 4'h2;
  localparam logic [3:0] OFS_STATUS     = 4'h3;

  // control field positions
  localparam int         CTRL_WIN_LSB   = 0;
  localparam int         CTRL_KIND_LSB  = 2;
  localparam int         CTRL_START_BIT = 4;

  // reset values and the shortest window length
  localparam logic [4:0] TRIM_RESET     = 5'h10;
  localparam logic [3:0] CTRL_RESET     = 4'h0;
  localparam logic [6:0] WIN_BITS_8     = 7'h08;

  // register bus request carried as one bundle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  // estimator state codes, one-hot
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_COUNT = 2'b10
  } est_state_t;

endpackage : xtal_trim_pkg
